//--- dma_ctrl_map.svh
/*
 * Constants for the eight-channel DMA controller: activation codes,
 * address step codes and fixed address fields.
 * Assumes inclusion by the controller module, its assertion checker and its test bench.
 */
`ifndef DMA_CTRL_MAP_SVH
`define DMA_CTRL_MAP_SVH

// ==========================================================================
// Activation sources
// ==========================================================================
`define ACT_TIMER0 3'h0
`define ACT_TIMER3 3'h3
`define ACT_SER_TXE 3'h4
`define ACT_SER_RXF 3'h5
`define ACT_EXT 3'h6
`define ACT_AUTO 3'h7

// ==========================================================================
// Memory address step codes
// ==========================================================================
`define STEP_FIXED 2'h0
`define STEP_INC 2'h1
`define STEP_DEC 2'h2

// ==========================================================================
// Address and count figures
// ==========================================================================
`define IO_PAGE 16'hFFFF
`define BYTE_STEP 24'h000001
`define WORD_STEP 24'h000002
`define FULL_COUNT 17'h10000
`define REPEAT_WRAP 17'h00100
`define CNT_ONE 17'h00001
`define BLK_ONE 8'h01

`endif

//--- dma_ctrl_pkg.sv
/*
 * Types shared by the DMA controller and its surroundings.
 * Assumes dma_ctrl_map.svh sits in the include path.
 */
package dma_ctrl_pkg;

    // ======================================================================
    // Transfer modes
    // ======================================================================
    typedef enum logic [2:0] {
        MODE_IO,
        MODE_IDLE,
        MODE_REPEAT,
        MODE_NORMAL,
        MODE_BLOCK
    } xfer_mode_t;

    // ======================================================================
    // Per-channel configuration and bus command
    // ======================================================================
    typedef struct packed {
        logic enable;
        xfer_mode_t mode;
        logic word;
        logic io_to_mem;
        logic [1:0] step;
        logic burst;
        logic fix_dst;
        logic [2:0] act_sel;
        logic [23:0] mem_addr;
        logic [7:0] io_addr;
        logic [15:0] count;
        logic [7:0] block;
    } chan_cfg_t;

    typedef struct packed {
        logic req;
        logic we;
        logic word;
        logic [23:0] addr;
        logic [15:0] wdata;
    } bus_cmd_t;

endpackage

//--- dma_ctrl.sv
/*
 * Eight-channel DMA controller: four channel pairs, each pair
 * run as two short-address channels or as one full-address channel, with a
 * single read-then-write bus engine shared by all channels.
 * Assumes a bus slave that answers each held request with a one-cycle ack,
 * and interrupt sources that pulse for one cycle on i_mclk.
 */
`timescale 1ns/10ps
`include "dma_ctrl_map.svh"

module dma_ctrl
    import dma_ctrl_pkg::*;
#(
    parameter int NUM_PAIRS = 4
) (
    // Clock, reset and enable
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Channel configuration, index 2p is channel A and 2p+1 channel B of pair p
    input wire chan_cfg_t i_cfg [2*NUM_PAIRS],
    // Activation sources
    input wire logic [3:0] i_timer_irq,
    input wire logic i_ser_txe,
    input wire logic i_ser_rxf,
    input wire logic [NUM_PAIRS-1:0] i_dma_request_in,
    // System bus
    output bus_cmd_t o_bus,
    input wire logic i_bus_ack,
    input wire logic [15:0] i_bus_rdata,
    // Status and pins
    output logic [2*NUM_PAIRS-1:0] o_ch_active,
    output logic [NUM_PAIRS-1:0] o_transfer_end_out
);

    localparam int NCH = 2 * NUM_PAIRS;

    // ======================================================================
    // Parameter check
    // ======================================================================
    generate
        if (NUM_PAIRS != 4) begin : g_bad_pairs
            $error("dma_ctrl serves exactly four channel pairs");
        end
    endgenerate

    typedef enum {S_IDLE, S_READ, S_WRITE} eng_state_t;

    eng_state_t state_reg;
    logic [2:0] ch_reg;
    logic [15:0] data_reg;
    logic [NCH-1:0] pend_reg;
    logic [NCH-1:0] act_reg;
    logic [NCH-1:0] en_d_reg;
    logic [23:0] addr_reg [NCH];
    logic [23:0] addr2_reg [NCH];
    logic [16:0] cnt_reg [NCH];
    logic [7:0] blk_reg [NCH];
    logic [NUM_PAIRS-1:0] dma_request_in_s1_reg, dma_request_in_s2_reg, dma_request_in_s3_reg;
    logic [NUM_PAIRS-1:0] dma_request_in_lvl_reg, dma_request_in_lvl_d_reg;
    logic [NUM_PAIRS-1:0] dma_request_in_rise;
    logic [NCH-1:0] full_ch, trig, start, can_run;
    logic [2:0] grant;
    logic grant_vld;
    logic xfer_done;

    // ======================================================================
    // External request synchroniser, three stages, last two must agree
    // ======================================================================
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            dma_request_in_s1_reg <= '0;
            dma_request_in_s2_reg <= '0;
            dma_request_in_s3_reg <= '0;
            dma_request_in_lvl_reg <= '0;
            dma_request_in_lvl_d_reg <= '0;
        end else if (i_ce) begin
            dma_request_in_s1_reg <= i_dma_request_in;
            dma_request_in_s2_reg <= dma_request_in_s1_reg;
            dma_request_in_s3_reg <= dma_request_in_s2_reg;
            dma_request_in_lvl_reg <= (dma_request_in_s2_reg & dma_request_in_s3_reg) | (dma_request_in_lvl_reg & (dma_request_in_s2_reg | dma_request_in_s3_reg));
            dma_request_in_lvl_d_reg <= dma_request_in_lvl_reg;
        end
    end

    // One request per filtered rising edge of the pin.
    assign dma_request_in_rise = dma_request_in_lvl_reg & ~dma_request_in_lvl_d_reg;

    // ======================================================================
    // Per-channel activation decode
    // ======================================================================
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_act
            localparam int PAIR = gi / 2;
            localparam int ACH = gi - (gi % 2);
            logic a_full;
            assign a_full = (i_cfg[ACH].mode == MODE_NORMAL) || (i_cfg[ACH].mode == MODE_BLOCK);
            // A full-address pair runs on channel A; channel B gives its address and step code only.
            assign full_ch[gi] = a_full;
            assign can_run[gi] = !(a_full && (gi % 2 == 1));
            assign start[gi] = i_cfg[gi].enable && !en_d_reg[gi] && can_run[gi];
            always_comb begin
                case (i_cfg[gi].act_sel)
                    `ACT_SER_TXE: trig[gi] = i_ser_txe;
                    `ACT_SER_RXF: trig[gi] = i_ser_rxf;
                    // Short-mode A channels take no external request.
                    `ACT_EXT: trig[gi] = dma_request_in_rise[PAIR] && (a_full || (gi % 2 == 1));
                    `ACT_AUTO: trig[gi] = a_full && (i_cfg[gi].mode == MODE_NORMAL);
                    default: trig[gi] = i_timer_irq[i_cfg[gi].act_sel[1:0]];
                endcase
            end
        end
    endgenerate

    // ======================================================================
    // Arbitration, lowest channel number first
    // ======================================================================
    always_comb begin
        grant = 3'h0;
        grant_vld = 1'b0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (pend_reg[i] && act_reg[i]) begin
                grant = 3'(i);
                grant_vld = 1'b1;
            end
        end
    end

    // ======================================================================
    // Address and count arithmetic for the channel on the bus
    // ======================================================================
    chan_cfg_t cur, bcfg;
    logic [23:0] unit, src_addr, dst_addr, nxt_addr, nxt_addr2;
    logic [16:0] nxt_cnt;
    logic [7:0] nxt_blk;
    logic is_full, is_block, is_auto, blk_last, unit_done, cnt_last, ch_end, lock;

    always_comb begin
        cur = i_cfg[ch_reg];
        bcfg = i_cfg[ch_reg | 3'h1];
        is_full = full_ch[ch_reg];
        is_block = is_full && (cur.mode == MODE_BLOCK);
        is_auto = is_full && (cur.mode == MODE_NORMAL) && (cur.act_sel == `ACT_AUTO);
        unit = cur.word ? `WORD_STEP : `BYTE_STEP;
        if (is_full) begin
            src_addr = addr_reg[ch_reg];
            dst_addr = addr2_reg[ch_reg];
        end else if (cur.io_to_mem) begin
            src_addr = {`IO_PAGE, cur.io_addr};
            dst_addr = addr_reg[ch_reg];
        end else begin
            src_addr = addr_reg[ch_reg];
            dst_addr = {`IO_PAGE, cur.io_addr};
        end
        nxt_addr = addr_reg[ch_reg];
        if (!(!is_full && cur.mode == MODE_IDLE)) begin
            if (cur.step == `STEP_INC) begin
                nxt_addr = addr_reg[ch_reg] + unit;
            end else if (cur.step == `STEP_DEC) begin
                nxt_addr = addr_reg[ch_reg] - unit;
            end
        end
        // Channel B's step code moves the destination of a full pair.
        nxt_addr2 = addr2_reg[ch_reg];
        if (bcfg.step == `STEP_INC) begin
            nxt_addr2 = addr2_reg[ch_reg] + unit;
        end else if (bcfg.step == `STEP_DEC) begin
            nxt_addr2 = addr2_reg[ch_reg] - unit;
        end
        blk_last = is_block && (blk_reg[ch_reg] == `BLK_ONE);
        unit_done = !is_block || blk_last;
        cnt_last = unit_done && (cnt_reg[ch_reg] == `CNT_ONE);
        nxt_blk = blk_last ? cur.block : blk_reg[ch_reg] - `BLK_ONE;
        nxt_cnt = unit_done ? cnt_reg[ch_reg] - `CNT_ONE : cnt_reg[ch_reg];
        if (blk_last) begin
            // The fixed block area returns to its start after every block.
            if (cur.fix_dst) begin
                nxt_addr2 = bcfg.mem_addr;
            end else begin
                nxt_addr = cur.mem_addr;
            end
        end
        if (cnt_last && !is_full && cur.mode == MODE_REPEAT) begin
            nxt_addr = cur.mem_addr;
            nxt_cnt = (cur.count[7:0] == 8'h00) ? `REPEAT_WRAP : {9'h000, cur.count[7:0]};
        end
        // A repeat channel never ends on its own; only enable low, or a full-address mode on channel A of its pair, stops it.
        ch_end = cnt_last && !(!is_full && cur.mode == MODE_REPEAT);
        lock = (is_block && !blk_last) || (is_auto && cur.burst && !cnt_last);
    end

    assign xfer_done = (state_reg == S_WRITE) && i_bus_ack;

    // ======================================================================
    // Channel state: load on enable, update after each write
    // ======================================================================
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            act_reg <= '0;
            en_d_reg <= '0;
            for (int i = 0; i < NCH; i++) begin
                addr_reg[i] <= 24'h000000;
                addr2_reg[i] <= 24'h000000;
                cnt_reg[i] <= 17'h00000;
                blk_reg[i] <= 8'h00;
            end
        end else if (i_ce) begin
            for (int i = 0; i < NCH; i++) begin
                // Only a rising enable loads the channel, so a held enable does not restart it.
                en_d_reg[i] <= i_cfg[i].enable;
                if (!i_cfg[i].enable || !can_run[i]) begin
                    act_reg[i] <= 1'b0;
                end else if (start[i]) begin
                    act_reg[i] <= 1'b1;
                    addr_reg[i] <= i_cfg[i].mem_addr;
                    addr2_reg[i] <= i_cfg[i | 1].mem_addr;
                    blk_reg[i] <= i_cfg[i].block;
                    if (!full_ch[i] && i_cfg[i].mode == MODE_REPEAT) begin
                        cnt_reg[i] <= (i_cfg[i].count[7:0] == 8'h00) ? `REPEAT_WRAP
                                    : {9'h000, i_cfg[i].count[7:0]};
                    end else begin
                        cnt_reg[i] <= (i_cfg[i].count == 16'h0000) ? `FULL_COUNT
                                    : {1'b0, i_cfg[i].count};
                    end
                end else if (xfer_done && ch_reg == 3'(i)) begin
                    addr_reg[i] <= nxt_addr;
                    addr2_reg[i] <= nxt_addr2;
                    cnt_reg[i] <= nxt_cnt;
                    blk_reg[i] <= nxt_blk;
                    if (ch_end) begin
                        act_reg[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // ======================================================================
    // Pending requests, a new request wins over the clear
    // ======================================================================
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            pend_reg <= '0;
        end else if (i_ce) begin
            for (int i = 0; i < NCH; i++) begin
                if (trig[i] && act_reg[i]) begin
                    pend_reg[i] <= 1'b1;
                end else if (!act_reg[i]) begin
                    pend_reg[i] <= 1'b0;
                end else if (xfer_done && ch_reg == 3'(i) && unit_done && !is_auto) begin
                    pend_reg[i] <= 1'b0;
                end
            end
        end
    end

    // ======================================================================
    // Bus engine: read the source, then write the destination
    // ======================================================================
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            state_reg <= S_IDLE;
            ch_reg <= 3'h0;
            data_reg <= 16'h0000;
            o_bus <= '0;
        end else if (i_ce) begin
            case (state_reg)
                S_IDLE: begin
                    if (grant_vld) begin
                        ch_reg <= grant;
                        state_reg <= S_READ;
                    end
                    o_bus <= '0;
                end
                S_READ: begin
                    // The request rises one cycle after entry, so every access starts from low.
                    if (!o_bus.req) begin
                        o_bus.req <= 1'b1;
                        o_bus.we <= 1'b0;
                        o_bus.word <= cur.word;
                        o_bus.addr <= src_addr;
                    end else if (i_bus_ack) begin
                        data_reg <= i_bus_rdata;
                        o_bus.req <= 1'b0;
                        state_reg <= S_WRITE;
                    end
                end
                S_WRITE: begin
                    if (!o_bus.req) begin
                        o_bus.req <= 1'b1;
                        o_bus.we <= 1'b1;
                        o_bus.addr <= dst_addr;
                        o_bus.wdata <= data_reg;
                    end else if (i_bus_ack) begin
                        o_bus.req <= 1'b0;
                        // Cycle steal frees the bus between transfers; auto-request burst and blocks hold it.
                        state_reg <= (lock && act_reg[ch_reg]) ? S_READ : S_IDLE;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                    o_bus <= '0;
                end
            endcase
        end
    end

    // ======================================================================
    // Status and transfer-end pins
    // ======================================================================
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_transfer_end_out <= '0;
            o_ch_active <= '0;
        end else if (i_ce) begin
            o_ch_active <= act_reg;
            for (int p = 0; p < NUM_PAIRS; p++) begin
                o_transfer_end_out[p] <= xfer_done && ch_end && (ch_reg[2:1] == 2'(p));
            end
        end
    end

endmodule

//--- dma_ctrl_assertions.sv
/*
 * Port checker for the DMA controller.
 * Assumes a bind to dma_ctrl with NUM_PAIRS handed on.
 */
`timescale 1ns/10ps
`include "dma_ctrl_map.svh"
module dma_ctrl_assertions
    import dma_ctrl_pkg::*;
#(
    parameter int NUM_PAIRS = 4
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Configuration and activation
    input wire chan_cfg_t i_cfg [2*NUM_PAIRS],
    input wire logic [3:0] i_timer_irq,
    input wire logic i_ser_txe,
    input wire logic i_ser_rxf,
    input wire logic [NUM_PAIRS-1:0] i_dma_request_in,
    // Bus and status
    input wire bus_cmd_t o_bus,
    input wire logic i_bus_ack,
    input wire logic [15:0] i_bus_rdata,
    input wire logic [2*NUM_PAIRS-1:0] o_ch_active,
    input wire logic [NUM_PAIRS-1:0] o_transfer_end_out
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    // ======================================================================
    // Bus access steps
    // ======================================================================
    logic [15:0] rd_hold;
    always_ff @(posedge i_mclk) begin
        if (i_bus_ack && !o_bus.we) begin
            rd_hold <= i_bus_rdata;
        end
    end
    sequence rd_done;
        o_bus.req && !o_bus.we && i_bus_ack;
    endsequence
    sequence wr_issue;
        o_bus.req && o_bus.we && o_bus.wdata[7:0] == rd_hold[7:0];
    endsequence

    req_held_a: assert property (o_bus.req && !i_bus_ack |=> o_bus.req && $stable(o_bus.addr) && $stable(o_bus.we))
        else $error("request dropped or changed before answer");
    ack_gap_a: assert property (i_bus_ack |=> !o_bus.req)
        else $error("request not released after answer");
    read_write_a: assert property (rd_done |=> !o_bus.req ##1 wr_issue)
        else $error("write does not follow read with its data");
    end_pulse_a: assert property (|o_transfer_end_out |=> o_transfer_end_out == '0)
        else $error("transfer end longer than one cycle");
    end_cause_a: assert property (|o_transfer_end_out |->
        ($past(i_bus_ack) && $past(o_bus.we)) || ($past(i_bus_ack, 2) && $past(o_bus.we, 2)))
        else $error("transfer end without a finished write");
    start_lat_a: assert property ($rose(i_cfg[0].enable) && i_ce |=> ##1 o_ch_active[0])
        else $error("channel not active two cycles after enable");
    full_b_off_a: assert property (i_cfg[4].mode >= MODE_NORMAL && $past(i_cfg[4].mode, 3) >= MODE_NORMAL
        |-> !o_ch_active[5])
        else $error("second channel of a full pair running");
    repeat_end_a: assert property (i_cfg[2].mode == MODE_REPEAT && i_cfg[2].enable && !i_cfg[3].enable
        |-> !o_transfer_end_out[1])
        else $error("repeat channel signalled transfer end");
    ext_a_off_a: assert property (i_cfg[0].enable && i_cfg[0].mode == MODE_IO && i_cfg[0].act_sel == `ACT_EXT
        && o_ch_active == 8'h01 |-> !o_bus.req)
        else $error("short channel A moved on external request");
endmodule

//--- dma_bus_mem.sv
/*
 * Bus slave model standing for memory and peripherals.
 * Assumes one held request at a time, answered after i_wait idle cycles.
 */
`timescale 1ns/10ps
module dma_bus_mem
    import dma_ctrl_pkg::*;
(
    // Clock and pacing
    input wire logic i_mclk,
    input wire logic [3:0] i_wait,
    // Bus
    input wire bus_cmd_t i_bus,
    output logic o_ack,
    output logic [15:0] o_rdata
);
    logic [3:0] wait_reg = 4'h0;
    initial o_ack = 1'b0;
    initial o_rdata = 16'h0000;
    always @(posedge i_mclk) begin
        o_ack <= 1'b0;
        // Read data outside the answer cycle is scrambled on purpose.
        o_rdata <= ~o_rdata;
        if (i_bus.req && !o_ack) begin
            if (wait_reg == i_wait) begin
                o_ack <= 1'b1;
                o_rdata <= i_bus.addr[15:0] ^ 16'h3C5A;
                wait_reg <= 4'h0;
            end else begin
                wait_reg <= wait_reg + 4'h1;
            end
        end
    end
endmodule

//--- dma_ctrl_test.sv
/*
 * Self-checking bench for the DMA controller with a bus slave model.
 * Assumes the package, header and design compile beforehand.
 */
`timescale 1ns/10ps
`include "dma_ctrl_map.svh"
module dma_ctrl_test
    import dma_ctrl_pkg::*;
;
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [3:0] timer, req_pin, wait_cyc, transfer_end_out;
    logic txe, rxf, ack, ce;
    logic [15:0] rdata;
    logic [7:0] act;
    bus_cmd_t bus;
    chan_cfg_t cfg [8];
    int err_count = 0;
    int total_checks = 0;
    int ends [4] = '{default: 0};
    logic [39:0] wq [$];
    logic [24:0] rq [$];

    always #4 i_mclk = ~i_mclk;

    dma_ctrl u_dma_ctrl (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(ce), .i_cfg(cfg), .i_timer_irq(timer),
        .i_ser_txe(txe), .i_ser_rxf(rxf), .i_dma_request_in(req_pin), .o_bus(bus), .i_bus_ack(ack),
        .i_bus_rdata(rdata), .o_ch_active(act), .o_transfer_end_out(transfer_end_out));
    dma_bus_mem u_dma_bus_mem (.i_mclk(i_mclk), .i_wait(wait_cyc), .i_bus(bus), .o_ack(ack), .o_rdata(rdata));

    // ======================================================================
    // Bus and pin monitor
    // ======================================================================
    always @(posedge i_mclk) begin
        if (ack === 1'b1 && bus.req === 1'b1 && bus.we === 1'b1) wq.push_back({bus.addr, bus.wdata});
        if (ack === 1'b1 && bus.req === 1'b1 && bus.we === 1'b0) rq.push_back({bus.word, bus.addr});
        for (int p = 0; p < 4; p++) begin
            if (transfer_end_out[p] === 1'b1) ends[p]++;
        end
    end

    // ======================================================================
    // Tasks
    // ======================================================================
    task automatic chk(input bit ok, input string m);
        total_checks++;
        if (!ok) begin
            err_count++;
            $display("[FAIL] %0t: %s", $time, m);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    function automatic chan_cfg_t mk(xfer_mode_t m, logic w, logic d, logic [1:0] s, logic [2:0] a,
        logic [23:0] ma, logic [7:0] ia, logic [15:0] n);
        mk = '{enable: 1'b0, mode: m, word: w, io_to_mem: d, step: s, burst: 1'b1, fix_dst: 1'b1,
            act_sel: a, mem_addr: ma, io_addr: ia, count: n, block: 8'h02};
    endfunction
    task automatic start(input int k, input chan_cfg_t c);
        cfg[k] = c;
        tick(1);
        cfg[k].enable = 1'b1;
        tick(3);
    endtask
    task automatic fire(input int a);
        if (a < 4) timer[a] = 1'b1;
        txe = (a == 4);
        rxf = (a == 5);
        tick(1);
        timer = 4'h0;
        txe = 1'b0;
        rxf = 1'b0;
    endtask
    task automatic xfer(input logic [23:0] src, input logic [23:0] dst, input logic w);
        logic [15:0] d;
        int n;
        d = src[15:0] ^ 16'h3C5A;
        n = 0;
        while (wq.size() == 0 && n < 200) begin
            tick(1);
            n++;
        end
        chk(wq.size() > 0 && rq.size() > 0, "no transfer seen");
        if (wq.size() > 0 && rq.size() > 0) begin
            chk(rq.pop_front() === {w, src} && wq[0][39:16] === dst, "address or size mismatch");
            chk(w ? wq[0][15:0] === d : wq[0][7:0] === d[7:0], "data mismatch");
            void'(wq.pop_front());
        end
    endtask
    task print_verdict;
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ======================================================================
    // Tests
    // ======================================================================
    initial begin
        timer = 4'h0;
        txe = 1'b0;
        rxf = 1'b0;
        ce = 1'b1;
        req_pin = 4'h0;
        wait_cyc = 4'h0;
        for (int k = 0; k < 8; k++) cfg[k] = '0;
        tick(16);
        i_rst_b = 1'b1;
        tick(2);
        chk(act === 8'h00 && transfer_end_out === 4'h0 && bus.req === 1'b0, "outputs not idle after reset");
        for (int a = 0; a < 6; a++) begin
            start(0, mk(MODE_IO, 1'b0, 1'b0, `STEP_INC, a[2:0], 24'h001000 + 24'(a), 8'h40 + 8'(a), 16'h0001));
            fire(a);
            xfer(24'h001000 + 24'(a), {`IO_PAGE, 8'h40 + 8'(a)}, 1'b0);
            tick(3);
            chk(ends[0] === a + 1, "no end after single transfer");
        end
        $display("test sources done");
        start(1, mk(MODE_IDLE, 1'b1, 1'b1, `STEP_INC, `ACT_EXT, 24'hABCDE0, 8'h10, 16'h0002));
        repeat (2) begin
            req_pin[0] = 1'b1;
            tick(8);
            req_pin[0] = 1'b0;
            xfer({`IO_PAGE, 8'h10}, 24'hABCDE0, 1'b1);
            tick(6);
        end
        chk(ends[0] === 7, "idle count end missing");
        $display("test idle done");
        start(2, mk(MODE_REPEAT, 1'b1, 1'b0, `STEP_DEC, `ACT_SER_TXE, 24'h000200, 8'h22, 16'h0002));
        for (int i = 0; i < 3; i++) begin
            fire(4);
            xfer(i == 1 ? 24'h0001FE : 24'h000200, {`IO_PAGE, 8'h22}, 1'b1);
        end
        tick(5);
        chk(ends[1] === 0 && act[2] === 1'b1, "repeat channel stopped");
        ce = 1'b0;
        cfg[2].enable = 1'b0;
        tick(4);
        chk(act[2] === 1'b1, "state moved while clock enable low");
        ce = 1'b1;
        tick(3);
        chk(act[2] === 1'b0, "repeat channel did not stop");
        $display("test repeat done");
        wait_cyc = 4'h2;
        cfg[5] = mk(MODE_IO, 1'b1, 1'b0, `STEP_INC, 3'h0, 24'h400000, 8'h00, 16'h0001);
        start(4, mk(MODE_NORMAL, 1'b1, 1'b0, `STEP_INC, `ACT_AUTO, 24'h300000, 8'h00, 16'h0003));
        cfg[5].enable = 1'b1;
        for (int i = 0; i < 3; i++) xfer(24'h300000 + 24'(2 * i), 24'h400000 + 24'(2 * i), 1'b1);
        tick(3);
        chk(ends[2] === 1, "auto run end missing");
        chk(act[5] === 1'b0, "B channel of a full pair ran");
        cfg[4] = mk(MODE_NORMAL, 1'b1, 1'b0, `STEP_FIXED, `ACT_AUTO, 24'h320000, 8'h00, 16'h0002);
        cfg[4].burst = 1'b0;
        start(4, cfg[4]);
        for (int i = 0; i < 2; i++) xfer(24'h320000, 24'h400000 + 24'(2 * i), 1'b1);
        tick(3);
        chk(ends[2] === 2, "cycle-steal run end missing");
        wait_cyc = 4'h0;
        $display("test auto done");
        cfg[7] = mk(MODE_IO, 1'b0, 1'b0, `STEP_INC, 3'h0, 24'h600000, 8'h00, 16'h0001);
        start(6, mk(MODE_BLOCK, 1'b0, 1'b0, `STEP_INC, `ACT_TIMER3, 24'h500000, 8'h00, 16'h0002));
        for (int i = 0; i < 4; i++) begin
            if (i % 2 == 0) fire(3);
            xfer(24'h500000 + 24'(i), 24'h600000 + 24'(i % 2), 1'b0);
        end
        tick(3);
        chk(ends[3] === 1, "block count end missing");
        cfg[7] = mk(MODE_IO, 1'b0, 1'b0, `STEP_DEC, 3'h0, 24'h700010, 8'h00, 16'h0001);
        cfg[6] = mk(MODE_BLOCK, 1'b0, 1'b0, `STEP_INC, `ACT_TIMER3, 24'h710000, 8'h00, 16'h0002);
        cfg[6].fix_dst = 1'b0;
        start(6, cfg[6]);
        for (int i = 0; i < 4; i++) begin
            if (i % 2 == 0) fire(3);
            xfer(24'h710000 + 24'(i % 2), 24'h700010 - 24'(i), 1'b0);
        end
        tick(3);
        chk(ends[3] === 2, "source-fixed block end missing");
        $display("test block done");
        start(0, mk(MODE_IO, 1'b0, 1'b0, `STEP_INC, `ACT_EXT, 24'h001000, 8'h40, 16'h0001));
        req_pin[0] = 1'b1;
        tick(30);
        req_pin[0] = 1'b0;
        tick(5);
        chk(wq.size() == 0 && rq.size() == 0 && act[0] === 1'b1, "short A took a pin request");
        $display("test pin refusal done");
        print_verdict;
    end

    initial begin
        repeat (20000) @(posedge i_mclk);
        err_count++;
        $display("[FAIL] %0t: watchdog expired", $time);
        print_verdict;
    end
endmodule

bind dma_ctrl dma_ctrl_assertions #(.NUM_PAIRS(NUM_PAIRS)) u_dma_ctrl_assertions (.i_mclk(i_mclk),
    .i_rst_b(i_rst_b), .i_ce(i_ce), .i_cfg(i_cfg), .i_timer_irq(i_timer_irq), .i_ser_txe(i_ser_txe),
    .i_ser_rxf(i_ser_rxf), .i_dma_request_in(i_dma_request_in), .o_bus(o_bus), .i_bus_ack(i_bus_ack),
    .i_bus_rdata(i_bus_rdata), .o_ch_active(o_ch_active), .o_transfer_end_out(o_transfer_end_out));
